// *** design/pbg_top.sv ***
// The register offsets and register access over Avalon-MM were left to the implementer.
`timescale 1ns/100ps
module pbg_top
	import pbg_pkg::*;
(
	input  wire logic                  mclk_in,
	input  wire logic                  rstn_in,
	// Avalon-MM slave
	input  wire logic [7:0]            avs_address_in,
	input  wire logic                  avs_read_in,
	input  wire logic                  avs_write_in,
	input  wire logic [31:0]           avs_writedata_in,
	output logic      [31:0]           avs_readdata_out,
	output logic                       avs_waitrequest_out,
	// Stages and assignable sources
	input  wire logic [NUM_DIN-1:0]    digital_in,
	input  wire logic [NUM_STAGES-1:0] stage_alarm_in,
	input  wire logic [NUM_STAGES-1:0] stage_trip_in,
	input  wire logic                  rev_interlock_phase_in,
	input  wire logic                  rev_interlock_ground_in,
	output logic      [NUM_STAGES-1:0] stage_enable_out,
	output logic      [NUM_STAGES-1:0] stage_alarm_out,
	output logic      [NUM_STAGES-1:0] trip_cmd_out,
	output logic                       prot_blocked_out
);

	// ----------------------------------------------------------------
	// Settings
	// ----------------------------------------------------------------
	logic                  func_active_r;
	logic                  prot_permit_r;
	pbg_src_sel_t          prot_src_r;
	logic [NUM_STAGES-1:0] mod_active_r;
	logic [NUM_STAGES-1:0] mod_permit_r;
	logic [NUM_STAGES-1:0] trip_perm_r;
	logic [NUM_STAGES-1:0] trip_permit_r;
	logic [31:0]           stage_src_r [NUM_STAGES];

	logic                  wr_go;
	logic [31:0]           rd_nxt;
	logic [NUM_SIGNALS-1:0] signals;
	logic                  prot_ok;
	logic                  prot_blocked;
	pbg_stage_out_t        stage_res [NUM_STAGES];

	// ----------------------------------------------------------------
	// Bus handshake
	// ----------------------------------------------------------------
	// Every access answers on the second edge; write lands on that edge
	assign wr_go = avs_write_in & ~avs_waitrequest_out;

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			avs_waitrequest_out <= 1'b1;
			avs_readdata_out    <= 32'h0000_0000;
		end else if ((avs_read_in | avs_write_in) & avs_waitrequest_out) begin
			avs_waitrequest_out <= 1'b0;
			avs_readdata_out    <= avs_read_in ? rd_nxt : 32'h0000_0000;
		end else begin
			avs_waitrequest_out <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			func_active_r <= CTRL_FUNC_RST;
			prot_permit_r <= CTRL_PERMIT_RST;
			prot_src_r    <= SRC_SEL_RST;
		end else if (wr_go) begin
			if (avs_address_in == REG_CTRL) begin
				func_active_r <= avs_writedata_in[CTRL_FUNC_BIT];
				prot_permit_r <= avs_writedata_in[CTRL_PERMIT_BIT];
			end
			if (avs_address_in == REG_PROT_SRC) begin
				prot_src_r <= pbg_sel_field(avs_writedata_in, 0);
			end
		end
	end

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			mod_active_r  <= MOD_ACTIVE_RST;
			mod_permit_r  <= MOD_PERMIT_RST;
			trip_perm_r   <= TRIP_PERM_RST;
			trip_permit_r <= TRIP_PERMIT_RST;
		end else if (wr_go) begin
			case (avs_address_in)
				REG_MOD_ACTIVE: mod_active_r <= avs_writedata_in[NUM_STAGES-1:0];
				REG_MOD_PERMIT: mod_permit_r <= avs_writedata_in[NUM_STAGES-1:0];
				REG_TRIP_PERM: trip_perm_r <= avs_writedata_in[NUM_STAGES-1:0];
				REG_TRIP_PERMIT: trip_permit_r <= avs_writedata_in[NUM_STAGES-1:0];
				default: ;
			endcase
		end
	end

	// Only the three source fields are kept; other bits read as zero
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			for (int i = 0; i < NUM_STAGES; i++) begin
				stage_src_r[i] <= 32'h0000_0000;
			end
		end else if (wr_go) begin
			for (int i = 0; i < NUM_STAGES; i++) begin
				if (avs_address_in == REG_STAGE_SRC0 + 8'(4 * i)) begin
					stage_src_r[i] <= avs_writedata_in & 32'h001f_1f1f;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Read decode
	// ----------------------------------------------------------------
	always_comb begin
		rd_nxt = 32'h0000_0000;
		case (avs_address_in)
			REG_CTRL: begin
				rd_nxt[CTRL_FUNC_BIT]   = func_active_r;
				rd_nxt[CTRL_PERMIT_BIT] = prot_permit_r;
			end
			REG_PROT_SRC: rd_nxt[SEL_W:0] = prot_src_r;
			REG_MOD_ACTIVE: rd_nxt[NUM_STAGES-1:0] = mod_active_r;
			REG_MOD_PERMIT: rd_nxt[NUM_STAGES-1:0] = mod_permit_r;
			REG_TRIP_PERM: rd_nxt[NUM_STAGES-1:0] = trip_perm_r;
			REG_TRIP_PERMIT: rd_nxt[NUM_STAGES-1:0] = trip_permit_r;
			REG_STATUS: begin
				rd_nxt[NUM_STAGES-1:0]                 = stage_enable_out;
				rd_nxt[STAT_TRIP_LSB +: NUM_STAGES]    = trip_cmd_out;
				rd_nxt[STAT_BLOCK_BIT]                 = prot_blocked_out;
			end
			REG_SIGNALS: rd_nxt[NUM_SIGNALS-1:0] = signals;
			default: begin
				for (int i = 0; i < NUM_STAGES; i++) begin
					if (avs_address_in == REG_STAGE_SRC0 + 8'(4 * i)) begin
						rd_nxt = stage_src_r[i];
					end
				end
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Assignable signal list
	// ----------------------------------------------------------------
	// RULE10: inputs and module outputs
	// Module outputs enter from flops, which keeps a stage that blocks on
	// its own alarm from forming a combinational loop
	assign signals = {stage_alarm_out, digital_in};

	// ----------------------------------------------------------------
	// Gating
	// ----------------------------------------------------------------
	pbg_prot_gate u_prot (
		.func_active_in    (func_active_r),
		.inhibit_permit_in (prot_permit_r),
		.source_in         (prot_src_r),
		.signals_in        (signals),
		.prot_ok_out       (prot_ok),
		.prot_blocked_out  (prot_blocked)
	);

	for (genvar g = 0; g < NUM_STAGES; g++) begin : g_stage
		pbg_stage_cfg_t cfg;
		logic           ri;

		always_comb begin
			cfg.active              = mod_active_r[g];
			cfg.inhibit_permit      = mod_permit_r[g];
			cfg.trip_perm_inhibit   = trip_perm_r[g];
			cfg.trip_inhibit_permit = trip_permit_r[g];
			cfg.inhibit_source_one  = pbg_sel_field(stage_src_r[g], SRC_ONE_LSB);
			cfg.inhibit_source_two  = pbg_sel_field(stage_src_r[g], SRC_TWO_LSB);
			cfg.trip_inhibit_source = pbg_sel_field(stage_src_r[g], SRC_TRIP_LSB);
			// RULE11: phase reverse interlock
			// RULE12: ground reverse interlock
			ri = (PHASE_STAGE_MASK[g] & rev_interlock_phase_in) |
			     (GROUND_STAGE_MASK[g] & rev_interlock_ground_in);
		end

		pbg_stage_gate u_gate (
			.prot_ok_in       (prot_ok),
			.cfg_in           (cfg),
			.signals_in       (signals),
			.rev_interlock_in (ri),
			.alarm_in         (stage_alarm_in[g]),
			.trip_in          (stage_trip_in[g]),
			.res_out          (stage_res[g])
		);
	end

	// ----------------------------------------------------------------
	// Output flops
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			stage_enable_out <= '0;
			stage_alarm_out  <= '0;
			trip_cmd_out     <= '0;
			prot_blocked_out <= 1'b0;
		end else begin
			for (int i = 0; i < NUM_STAGES; i++) begin
				stage_enable_out[i] <= stage_res[i].enable;
				stage_alarm_out[i]  <= stage_res[i].alarm;
				// RULE13: gated trip
				trip_cmd_out[i]     <= stage_res[i].trip;
			end
			prot_blocked_out <= prot_blocked;
		end
	end

endmodule // pbg_top

// *** design/pbg_pkg.sv ***
// Overview of operation
// RULE1: Whole protection off stops every stage.
// RULE2: Each module has own permanent on/off.
// RULE3: Permanent suppression never lets stage trip.
// RULE4: Device block needs permit and assigned source.
// RULE5: Device blocked exactly while its signal asserted.
// RULE6: Module blockable only with its permit set.
// RULE7: Permitted module blocked by either source.
// RULE8: Trip blockable only with trip permit set.
// RULE9: Permitted trip suppressed while source active.
// RULE10: Inputs and module outputs are valid sources.
// RULE11: Phase stages also blocked by reverse interlock.
// RULE12: Ground stages also blocked by reverse interlock.
// RULE13: Enable ANDs settings; trip gated twice more.
package pbg_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int NUM_STAGES  = 8;
	localparam int NUM_DIN     = 8;
	localparam int NUM_SIGNALS = NUM_STAGES + NUM_DIN;
	localparam int SEL_W       = 4;

	// Stage kinds: bit set marks a phase or ground current stage
	localparam logic [7:0] PHASE_STAGE_MASK  = 8'h0f;
	localparam logic [7:0] GROUND_STAGE_MASK = 8'h30;

	// ----------------------------------------------------------------
	// Register map, byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL         = 8'h00;
	localparam logic [7:0] REG_PROT_SRC     = 8'h04;
	localparam logic [7:0] REG_MOD_ACTIVE   = 8'h08;
	localparam logic [7:0] REG_MOD_PERMIT   = 8'h0c;
	localparam logic [7:0] REG_TRIP_PERM    = 8'h10;
	localparam logic [7:0] REG_TRIP_PERMIT  = 8'h14;
	localparam logic [7:0] REG_STATUS       = 8'h18;
	localparam logic [7:0] REG_SIGNALS      = 8'h1c;
	localparam logic [7:0] REG_STAGE_SRC0   = 8'h20;
	localparam logic [7:0] REG_STAGE_SRC_END = 8'h3c;

	// Field positions
	localparam int CTRL_FUNC_BIT   = 0;
	localparam int CTRL_PERMIT_BIT = 1;
	localparam int SRC_ONE_LSB     = 0;
	localparam int SRC_TWO_LSB     = 8;
	localparam int SRC_TRIP_LSB    = 16;
	localparam int SRC_ASSIGN_BIT  = 4;
	localparam int STAT_TRIP_LSB   = 8;
	localparam int STAT_BLOCK_BIT  = 16;

	// Reset values
	localparam logic       CTRL_FUNC_RST   = 1'b0;
	localparam logic       CTRL_PERMIT_RST = 1'b0;
	localparam logic [7:0] MOD_ACTIVE_RST  = 8'h00;
	localparam logic [7:0] MOD_PERMIT_RST  = 8'h00;
	localparam logic [7:0] TRIP_PERM_RST   = 8'h00;
	localparam logic [7:0] TRIP_PERMIT_RST = 8'h00;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic             assigned;
		logic [SEL_W-1:0] index;
	} pbg_src_sel_t;

	localparam pbg_src_sel_t SRC_SEL_RST = '{assigned: 1'b0, index: 4'h0};

	typedef struct packed {
		logic         active;
		logic         inhibit_permit;
		logic         trip_perm_inhibit;
		logic         trip_inhibit_permit;
		pbg_src_sel_t inhibit_source_one;
		pbg_src_sel_t inhibit_source_two;
		pbg_src_sel_t trip_inhibit_source;
	} pbg_stage_cfg_t;

	typedef struct packed {
		logic enable;
		logic alarm;
		logic trip;
	} pbg_stage_out_t;

	// Assigned source level; an unassigned source never blocks
	function automatic logic pbg_pick(input logic [NUM_SIGNALS-1:0] list,
	                                  input pbg_src_sel_t sel);
		pbg_pick = sel.assigned & list[sel.index];
	endfunction

	function automatic pbg_src_sel_t pbg_sel_field(input logic [31:0] word, input int lsb);
		pbg_sel_field = pbg_src_sel_t'(word[lsb +: SEL_W+1]);
	endfunction

endpackage

// *** design/pbg_prot_gate.sv ***
`timescale 1ns/100ps
module pbg_prot_gate
	import pbg_pkg::*;
(
	input  wire logic                   func_active_in,
	input  wire logic                   inhibit_permit_in,
	input  wire pbg_src_sel_t           source_in,
	input  wire logic [NUM_SIGNALS-1:0] signals_in,
	output logic                        prot_ok_out,
	output logic                        prot_blocked_out
);
	logic ext_block;

	always_comb begin
		// RULE4: permit plus source
		// RULE5: follows the signal level
		ext_block = inhibit_permit_in & pbg_pick(signals_in, source_in);
		prot_blocked_out = ext_block;
		// RULE1: function switch gates all
		prot_ok_out = func_active_in & ~ext_block;
	end
endmodule // pbg_prot_gate

// *** design/pbg_stage_gate.sv ***
`timescale 1ns/100ps
module pbg_stage_gate
	import pbg_pkg::*;
(
	input  wire logic                   prot_ok_in,
	input  wire pbg_stage_cfg_t         cfg_in,
	input  wire logic [NUM_SIGNALS-1:0] signals_in,
	input  wire logic                   rev_interlock_in,
	input  wire logic                   alarm_in,
	input  wire logic                   trip_in,
	output pbg_stage_out_t              res_out
);
	logic mod_block;
	logic trip_block;
	logic enable;

	always_comb begin
		// RULE6: permit required
		// RULE7: either source blocks
		mod_block = cfg_in.inhibit_permit &
		            (pbg_pick(signals_in, cfg_in.inhibit_source_one) |
		             pbg_pick(signals_in, cfg_in.inhibit_source_two));
		// RULE8: trip permit required
		// RULE9: while source active
		trip_block = cfg_in.trip_inhibit_permit &
		             pbg_pick(signals_in, cfg_in.trip_inhibit_source);
		// RULE2: module own switch
		// RULE13: AND of all conditions
		enable = prot_ok_in & cfg_in.active & ~mod_block & ~rev_interlock_in;
		res_out.enable = enable;
		res_out.alarm  = enable & alarm_in;
		// RULE3: permanent trip suppression
		res_out.trip   = enable & trip_in & ~cfg_in.trip_perm_inhibit & ~trip_block;
	end
endmodule // pbg_stage_gate

// *** verif/pbg_top_asserts.sv ***
`timescale 1ns/100ps
module pbg_top_asserts
	import pbg_pkg::*;
(
	input  wire logic                  mclk_in,
	input  wire logic                  rstn_in,
	input  wire logic                  avs_read_in,
	input  wire logic                  avs_write_in,
	input  wire logic                  avs_waitrequest_out,
	input  wire logic [NUM_STAGES-1:0] stage_alarm_in,
	input  wire logic [NUM_STAGES-1:0] stage_trip_in,
	input  wire logic                  rev_interlock_phase_in,
	input  wire logic                  rev_interlock_ground_in,
	input  wire logic [NUM_STAGES-1:0] stage_enable_out,
	input  wire logic [NUM_STAGES-1:0] stage_alarm_out,
	input  wire logic [NUM_STAGES-1:0] trip_cmd_out,
	input  wire logic                  prot_blocked_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rstn_in);
	// ----------------------------------------------------------------
	// Gating path
	// ----------------------------------------------------------------
	property p_trip_en; (trip_cmd_out & ~stage_enable_out) == 8'h00; endproperty
	a_trip_en: assert property (p_trip_en) else $error("trip without enable");
	property p_trip_src; (trip_cmd_out & ~$past(stage_trip_in)) == 8'h00; endproperty
	a_trip_src: assert property (p_trip_src) else $error("trip without request");
	property p_alarm;
		stage_alarm_out == (stage_enable_out & $past(stage_alarm_in));
	endproperty
	a_alarm: assert property (p_alarm) else $error("alarm not gated by enable");
	property p_ri_phase;
		$past(rev_interlock_phase_in) |-> (stage_enable_out & PHASE_STAGE_MASK) == 8'h00;
	endproperty
	a_ri_phase: assert property (p_ri_phase) else $error("phase stage not interlocked");
	property p_ri_ground;
		$past(rev_interlock_ground_in) |-> (stage_enable_out & GROUND_STAGE_MASK) == 8'h00;
	endproperty
	a_ri_ground: assert property (p_ri_ground) else $error("ground stage not interlocked");
	property p_blocked; prot_blocked_out |-> stage_enable_out == 8'h00; endproperty
	a_blocked: assert property (p_blocked) else $error("stage enabled while blocked");
	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	property p_wait_one; !avs_waitrequest_out |=> avs_waitrequest_out; endproperty
	a_wait_one: assert property (p_wait_one) else $error("answer longer than one cycle");
	property p_wait_cause; $fell(avs_waitrequest_out) |-> $past(avs_read_in || avs_write_in); endproperty
	a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
	c_blocked: cover property (prot_blocked_out);
	c_ri: cover property ($past(rev_interlock_ground_in) && stage_enable_out != 8'h00);
	c_write: cover property ($fell(avs_waitrequest_out) && avs_write_in);
endmodule // pbg_top_asserts

// *** verif/pbg_stage_model.sv ***
`timescale 1ns/100ps
module pbg_stage_model (
	input  wire logic       mclk_in,
	input  wire logic [7:0] din_set_in,
	input  wire logic [7:0] alarm_set_in,
	input  wire logic [7:0] trip_set_in,
	input  wire logic       ri_ph_set_in,
	input  wire logic       ri_gr_set_in,
	output logic      [7:0] digital_out = 8'h00,
	output logic      [7:0] alarm_out = 8'h00,
	output logic      [7:0] trip_out = 8'h00,
	output logic            ri_ph_out = 1'b0,
	output logic            ri_gr_out = 1'b0
);
	always_ff @(posedge mclk_in) digital_out <= din_set_in;
	// Stage outputs lag the request by one edge, like a real pickup
	always_ff @(posedge mclk_in) begin
		alarm_out <= alarm_set_in;
		trip_out <= trip_set_in;
	end
	always_ff @(posedge mclk_in) begin
		ri_ph_out <= ri_ph_set_in;
		ri_gr_out <= ri_gr_set_in;
	end
endmodule // pbg_stage_model

// *** verif/protection_blocking_gate_test.sv ***
`timescale 1ns/100ps
module protection_blocking_gate_test import pbg_pkg::*;;
	logic        mclk_in = 1'b0;
	logic        rstn_in = 1'b0;
	logic [7:0]  avs_address_in = 8'h00;
	logic        avs_read_in = 1'b0;
	logic        avs_write_in = 1'b0;
	logic [31:0] avs_writedata_in = 32'h0;
	logic [31:0] avs_readdata_out, q;
	logic        avs_waitrequest_out, prot_blocked_out, ri_ph_s = 1'b0, ri_gr_s = 1'b0;
	logic [7:0]  din_s = 8'h00, alm_s = 8'h00, trp_s = 8'h00;
	logic [7:0]  digital_in, stage_alarm_in, stage_trip_in;
	logic [7:0]  stage_enable_out, stage_alarm_out, trip_cmd_out;
	logic        rev_interlock_phase_in, rev_interlock_ground_in;
	int          num_errors = 0;
	int          cmp_count = 0;
	always #12.5 mclk_in = ~mclk_in;
	pbg_stage_model model (.mclk_in(mclk_in), .din_set_in(din_s), .alarm_set_in(alm_s),
		.trip_set_in(trp_s), .ri_ph_set_in(ri_ph_s), .ri_gr_set_in(ri_gr_s),
		.digital_out(digital_in), .alarm_out(stage_alarm_in), .trip_out(stage_trip_in),
		.ri_ph_out(rev_interlock_phase_in), .ri_gr_out(rev_interlock_ground_in));
	pbg_top uut (.mclk_in(mclk_in), .rstn_in(rstn_in), .avs_address_in(avs_address_in),
		.avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
		.avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(avs_waitrequest_out), .digital_in(digital_in),
		.stage_alarm_in(stage_alarm_in), .stage_trip_in(stage_trip_in),
		.rev_interlock_phase_in(rev_interlock_phase_in),
		.rev_interlock_ground_in(rev_interlock_ground_in),
		.stage_enable_out(stage_enable_out), .stage_alarm_out(stage_alarm_out),
		.trip_cmd_out(trip_cmd_out), .prot_blocked_out(prot_blocked_out));
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic summarize();
		$display("checks %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Request held until waitrequest is sampled low at a rising edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
	                   output logic [31:0] rd);
		@(posedge mclk_in);
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_read_in <= !w;
		avs_write_in <= w;
		do @(posedge mclk_in); while (avs_waitrequest_out !== 1'b0);
		rd = avs_readdata_out;
		avs_read_in <= 1'b0;
		avs_write_in <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] t;
		bus(1'b1, a, d, t);
	endtask
	// Four edges cover the model stage, the register and one alarm hop
	task automatic outs(input logic [7:0] en, input logic [7:0] tr, input logic bl);
		repeat (4) @(posedge mclk_in);
		chk("enable", {24'h0, stage_enable_out}, {24'h0, en});
		chk("trip", {24'h0, trip_cmd_out}, {24'h0, tr});
		chk("blocked", {31'h0, prot_blocked_out}, {31'h0, bl});
	endtask
	initial begin
		repeat (5000) @(posedge mclk_in);
		num_errors++;
		summarize();
	end
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		repeat (16) @(posedge mclk_in);
		rstn_in <= 1'b1;
		for (int a = 0; a <= 20; a += 4) begin
			bus(1'b0, 8'(a), 32'h0, q);
			chk("reset value", q, 32'h0);
		end
		bus(1'b0, 8'h40, 32'h0, q);
		chk("unmapped", q, 32'h0);
		wr(REG_STAGE_SRC0 + 8'h14, 32'hffff_ffff);
		bus(1'b0, REG_STAGE_SRC0 + 8'h14, 32'h0, q);
		chk("stage source mask", q, 32'h001f_1f1f);
		wr(REG_MOD_ACTIVE, 32'hff);
		outs(8'h00, 8'h00, 1'b0);
		trp_s <= 8'hff;
		wr(REG_CTRL, 32'h1);
		outs(8'hff, 8'hff, 1'b0);
		wr(REG_MOD_ACTIVE, 32'hfe);
		outs(8'hfe, 8'hfe, 1'b0);
		wr(REG_TRIP_PERM, 32'h02);
		outs(8'hfe, 8'hfc, 1'b0);
		wr(REG_TRIP_PERM, 32'h0);
		wr(REG_PROT_SRC, 32'h03);
		wr(REG_CTRL, 32'h3);
		din_s <= 8'h08;
		outs(8'hfe, 8'hfe, 1'b0);
		wr(REG_PROT_SRC, 32'h13);
		outs(8'h00, 8'h00, 1'b1);
		din_s <= 8'h00;
		outs(8'hfe, 8'hfe, 1'b0);
		din_s <= 8'h08;
		wr(REG_CTRL, 32'h1);
		outs(8'hfe, 8'hfe, 1'b0);
		wr(REG_STAGE_SRC0 + 8'h08, 32'h13);
		outs(8'hfe, 8'hfe, 1'b0);
		wr(REG_MOD_PERMIT, 32'h04);
		outs(8'hfa, 8'hfa, 1'b0);
		wr(REG_STAGE_SRC0 + 8'h18, 32'h1300);
		wr(REG_MOD_PERMIT, 32'h44);
		outs(8'hba, 8'hba, 1'b0);
		din_s <= 8'h00;
		outs(8'hfe, 8'hfe, 1'b0);
		wr(REG_MOD_ACTIVE, 32'hff);
		wr(REG_STAGE_SRC0 + 8'h1c, 32'h18_0000);
		alm_s <= 8'h01;
		outs(8'hff, 8'hff, 1'b0);
		chk("alarm", {24'h0, stage_alarm_out}, 32'h01);
		bus(1'b0, REG_SIGNALS, 32'h0, q);
		chk("signals", q, 32'h0000_0100);
		wr(REG_TRIP_PERMIT, 32'h80);
		outs(8'hff, 8'h7f, 1'b0);
		alm_s <= 8'h00;
		outs(8'hff, 8'hff, 1'b0);
		ri_ph_s <= 1'b1;
		outs(8'hf0, 8'hf0, 1'b0);
		ri_ph_s <= 1'b0;
		ri_gr_s <= 1'b1;
		outs(8'hcf, 8'hcf, 1'b0);
		bus(1'b0, REG_STATUS, 32'h0, q);
		chk("status", q, 32'h0000_cfcf);
		ri_gr_s <= 1'b0;
		rstn_in <= 1'b0;
		repeat (2) @(posedge mclk_in);
		rstn_in <= 1'b1;
		outs(8'h00, 8'h00, 1'b0);
		bus(1'b0, REG_MOD_ACTIVE, 32'h0, q);
		chk("active after reset", q, 32'h0);
		summarize();
	end
endmodule // protection_blocking_gate_test
bind pbg_top pbg_top_asserts chk_i (.mclk_in(mclk_in), .rstn_in(rstn_in),
	.avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
	.avs_waitrequest_out(avs_waitrequest_out), .stage_alarm_in(stage_alarm_in),
	.stage_trip_in(stage_trip_in), .rev_interlock_phase_in(rev_interlock_phase_in),
	.rev_interlock_ground_in(rev_interlock_ground_in), .stage_enable_out(stage_enable_out),
	.stage_alarm_out(stage_alarm_out), .trip_cmd_out(trip_cmd_out),
	.prot_blocked_out(prot_blocked_out));
